/* File: hdl/dcpp_pkg.sv */
// Package of constants and carrier types for the direct color palette ports
package dcpp_pkg;

  // ==========================================================================
  // Register select codes
  // ==========================================================================
  localparam logic [2:0] SEL_WR_ADDR = 3'h0;  // Write address register
  localparam logic [2:0] SEL_COLOR = 3'h1;    // Color value
  localparam logic [2:0] SEL_MASK = 3'h2;     // Pixel mask / identification
  localparam logic [2:0] SEL_RD_ADDR = 3'h3;  // Read address register
  localparam logic [2:0] SEL_CMD = 3'h6;      // Command register

  // ==========================================================================
  // Command register fields and reset values
  // ==========================================================================
  localparam int CMD_DIRECT_BIT = 7;         // Direct mode bit
  localparam int CMD_MODE_HI = 7;            // Mode field top
  localparam int CMD_MODE_LO = 5;            // Mode field bottom
  localparam int CMD_PULSE_HI = 4;           // Pulse enable bits top
  localparam int CMD_PULSE_LO = 2;           // Pulse enable bits bottom
  localparam logic [2:0] MODE_D15 = 3'h5;    // 15-bit direct code
  localparam logic [2:0] MODE_D16 = 3'h6;    // 16-bit direct code
  localparam logic [2:0] MODE_D24 = 3'h7;    // 24-bit direct code
  localparam logic [7:0] CMD_RESET = 8'h00;  // Look-up mode after reset
  localparam logic [7:0] MASK_RESET = 8'hFF; // Mask passes every bit
  localparam logic [2:0] KEY_READS = 3'h4;   // Mask reads that open command access
  localparam logic [1:0] LAST_PH_D16 = 2'h1; // Last byte phase, 15/16-bit
  localparam logic [1:0] LAST_PH_D24 = 2'h2; // Last byte phase, 24-bit
  localparam int COLOR_W = 6;                // Color component width
  localparam int COLOR_PAD = 2;              // Zero bits below a table component

  // ==========================================================================
  // Operating modes and carrier types
  // ==========================================================================
  typedef enum logic [1:0] {DCPP_LUT, DCPP_D15, DCPP_D16, DCPP_D24} dcpp_mode_t;

  typedef struct packed {
    logic [7:0] red;    // Red converter input
    logic [7:0] green;  // Green converter input
    logic [7:0] blue;   // Blue converter input
  } dcpp_rgb_t;

  typedef struct packed {
    dcpp_rgb_t rgb;      // Converter inputs
    logic blank_n;       // Display enabled
    logic sync_on;       // Sync pedestal on
  } dcpp_video_t;

  typedef struct packed {
    logic [7:0] pix;     // Pixel byte
    logic blank_n;       // Blank control
    logic sync_n;        // Sync control
  } dcpp_pin_t;

endpackage

/* File: hdl/dcpp_core.sv */
// Pixel path, blank/sync pipeline and host register port of the color palette
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1: Capture pixel byte every rising clock
// RQ2: Mask ANDs pixel before table address
// RQ3: Table of 256 entries, 18 bits
// RQ4: Pixel rate one, two or three clocks
// RQ5: Direct modes bypass table, blue first
// RQ6: Blank low forces outputs to blanking
// RQ7: Blank delayed same as pixel data
// RQ8: Blank sampled only on byte-zero edges
// RQ9: Sync delayed like pixels, byte-zero sampled
// RQ10: Sync high turns pedestal current on
// RQ11: Three command bits gate each pedestal
// RQ12: Controller asserts sync only while blanked
// RQ13: Setup pin selects blanking pedestal level
// RQ14: Sense low when output above threshold
// RQ15: Read latches select, drives, then releases
// RQ16: Write latches select, data at strobe rise
// RQ17: Color transfers use six low bits
// RQ18: Four mask reads expose command register
// RQ19: Host port synchronized to pixel clock
// RQ20: Table access without display disturbance
// RQ21: Look-up after reset, codes select direct
// RQ22: Latency three, four or six clocks
// RQ23: Table component on top six bits
// RQ24: Select codes map the registers
// RQ25: Blank low resets byte-phase counter; code only holds it at zero when blank is low on byte zero
// RQ26: Controller sends bytes on consecutive clocks
module dcpp_core
  import dcpp_pkg::*;
#(
  parameter int LUT_DEPTH = 256,         // Table entries
  parameter logic [7:0] ID_VALUE = 8'h5A // Identification value, arbitrary
) (
  input wire logic REF_CLK,              // Pixel clock
  input wire logic RST_N,                // Synchronous reset, active low
  input wire logic [7:0] PIXEL_IN,       // Pixel bus
  input wire logic BLANK_N,              // Blank control, active low
  input wire logic SYNC_N,               // Sync control, active low
  input wire logic SETUP,                // Setup pedestal select
  input wire logic SLEEP,                // Sleep mode request
  input wire logic [2:0] OVER_THRESH,    // Comparator results per output
  input wire logic RD_N,                 // Host read strobe, active low
  input wire logic WR_N,                 // Host write strobe, active low
  input wire logic [2:0] REG_SELECT,     // Register select lines
  input wire logic [7:0] HOST_DATA_IN,   // Host data bus, input side
  output logic [7:0] HOST_DATA_OUT,      // Host data bus, output side
  output logic HOST_DATA_OE,             // Host data bus drive enable
  output logic [7:0] DAC_RED,            // Red converter input
  output logic [7:0] DAC_GREEN,          // Green converter input
  output logic [7:0] DAC_BLUE,           // Blue converter input
  output logic DAC_BLANK_N,              // Converter enabled, low blanks
  output logic [2:0] SYNC_PEDESTAL,      // Sync pedestal on per output
  output logic SETUP_PEDESTAL,           // Blanking pedestal at 7.5 IRE
  output logic SENSE_N                   // Monitor sense, active low
);

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Decode the command mode field
  function automatic dcpp_mode_t dcpp_decode(input logic [7:0] cmd);
    dcpp_mode_t m;
    m = DCPP_LUT;
    if (cmd[CMD_DIRECT_BIT]) begin
      case (cmd[CMD_MODE_HI:CMD_MODE_LO])
        MODE_D15: m = DCPP_D15;
        MODE_D16: m = DCPP_D16;
        MODE_D24: m = DCPP_D24;
        default: m = DCPP_LUT;
      endcase
    end
    return m;
  endfunction

  // Expand a six-bit component to converter width
  function automatic logic [7:0] dcpp_widen(input logic [5:0] c);
    return {c, {COLOR_PAD{1'b0}}}; // RQ23
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [2:0] rd_s;           // Read strobe synchroniser chain
    logic [2:0] wr_s;           // Write strobe synchroniser chain
    logic [2:0] sel_rd;         // Select latched at read start
    logic [2:0] sel_wr;         // Select latched at write start
    logic [7:0] wdata;          // Write data captured at strobe rise
    logic [7:0] rdata;          // Read data held for the bus
    logic oe;                   // Bus drive
    logic [7:0] cmd;            // Command register
    logic [7:0] mask;           // Pixel mask register
    logic [7:0] waddr;          // Table write address
    logic [7:0] raddr;          // Table read address
    logic [1:0] wphase;         // Write color component index
    logic [1:0] rphase;         // Read color component index
    logic [11:0] wcol;          // Red and green gathered for a write
    logic [2:0] key_cnt;        // Consecutive mask reads
    dcpp_pin_t pin;             // Registered pins
    logic [1:0] phase;          // Direct byte phase
    logic [7:0] byte0;          // First direct byte
    logic [7:0] byte1;          // Second direct byte
    logic hold_blank_n;         // Blank captured with byte zero
    logic hold_sync_n;          // Sync captured with byte zero
    dcpp_video_t st1;           // Pipeline stage one
    dcpp_video_t st2;           // Pipeline stage two
    dcpp_video_t st3;           // Pipeline stage three
    dcpp_video_t st4;           // Pipeline stage four
    dcpp_video_t out;           // Converter register
    logic [7:0] last_idx;       // Last pixel index shown
    logic sense_n;              // Registered sense
  } dcpp_state_t;

  dcpp_state_t r;              // Current state
  dcpp_state_t next_r;         // Next state
  logic [17:0] lut [LUT_DEPTH]; // Color table storage RQ3
  logic lut_we;                // Table write this cycle
  logic [7:0] lut_wa;          // Table write address
  logic [17:0] lut_wd;         // Table write data
  dcpp_mode_t mode;            // Current mode
  logic [1:0] last_ph;         // Last phase for mode
  logic rd_fall, rd_rise;      // Synchronised read edges
  logic wr_fall, wr_rise;      // Synchronised write edges
  logic [7:0] idx;             // Masked table index
  logic [17:0] entry;          // Table output
  dcpp_video_t lut_px;         // Look-up pixel
  dcpp_video_t dir_px;         // Assembled direct pixel

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Whole datapath and host port in one combinational process
  always_comb begin
    next_r = r;
    lut_we = 1'b0;
    lut_wa = r.waddr;
    lut_wd = {r.wcol, HOST_DATA_IN[COLOR_W-1:0]};
    mode = dcpp_decode(r.cmd); // RQ21
    last_ph = (mode == DCPP_D24) ? LAST_PH_D24 : LAST_PH_D16;
    // Host strobes cross over two flops; edges from the later pair
    next_r.rd_s = {r.rd_s[1:0], RD_N}; // RQ19
    next_r.wr_s = {r.wr_s[1:0], WR_N}; // RQ19
    rd_fall = r.rd_s[2] && !r.rd_s[1];
    rd_rise = !r.rd_s[2] && r.rd_s[1];
    wr_fall = r.wr_s[2] && !r.wr_s[1];
    wr_rise = !r.wr_s[2] && r.wr_s[1];

    // Read cycle: latch select and fetch data at strobe fall
    if (rd_fall) begin
      next_r.sel_rd = REG_SELECT; // RQ15
      next_r.oe = 1'b1; // RQ15
      next_r.rdata = 8'h00;
      case (REG_SELECT) // RQ24
        SEL_WR_ADDR: next_r.rdata = r.waddr;
        SEL_RD_ADDR: next_r.rdata = r.raddr;
        SEL_COLOR: begin
          // Six low bits only
          case (r.rphase)
            2'h0: next_r.rdata = {2'h0, lut[r.raddr][17:12]}; // RQ17
            2'h1: next_r.rdata = {2'h0, lut[r.raddr][11:6]}; // RQ17
            default: next_r.rdata = {2'h0, lut[r.raddr][5:0]}; // RQ17
          endcase
        end
        SEL_MASK: begin
          // Fourth read shows identity, further reads the command
          if (r.key_cnt == KEY_READS) begin
            next_r.rdata = r.cmd; // RQ18
          end else if (r.key_cnt == KEY_READS - 3'h1) begin
            next_r.rdata = ID_VALUE; // RQ24
          end else begin
            next_r.rdata = r.mask;
          end
        end
        SEL_CMD: next_r.rdata = r.cmd;
        default: next_r.rdata = 8'h00;
      endcase
    end
    // Read end: release bus and advance counters
    if (rd_rise) begin
      next_r.oe = 1'b0; // RQ15
      if (r.sel_rd == SEL_MASK) begin
        if (r.key_cnt != KEY_READS) begin
          next_r.key_cnt = r.key_cnt + 3'h1; // RQ18
        end
      end else begin
        next_r.key_cnt = 3'h0;
      end
      if (r.sel_rd == SEL_COLOR) begin
        next_r.rphase = (r.rphase == 2'h2) ? 2'h0 : r.rphase + 2'h1;
        if (r.rphase == 2'h2) begin
          next_r.raddr = r.raddr + 8'h01;
        end
      end
    end

    // Write cycle: latch destination at strobe fall
    if (wr_fall) begin
      next_r.sel_wr = REG_SELECT; // RQ16
    end
    // Data sampled at strobe rise
    if (wr_rise) begin
      next_r.wdata = HOST_DATA_IN; // RQ16
      // Any write breaks the mask read sequence except the keyed command write
      if (!(r.sel_wr == SEL_MASK && r.key_cnt == KEY_READS)) begin
        next_r.key_cnt = 3'h0;
      end
      case (r.sel_wr) // RQ24
        SEL_WR_ADDR: begin
          next_r.waddr = HOST_DATA_IN;
          next_r.wphase = 2'h0;
        end
        SEL_RD_ADDR: begin
          next_r.raddr = HOST_DATA_IN;
          next_r.rphase = 2'h0;
        end
        SEL_COLOR: begin
          // Gather red, green then commit blue
          case (r.wphase)
            2'h0: next_r.wcol[11:6] = HOST_DATA_IN[COLOR_W-1:0]; // RQ17
            2'h1: next_r.wcol[5:0] = HOST_DATA_IN[COLOR_W-1:0]; // RQ17
            default: begin
              lut_we = 1'b1;
              next_r.waddr = r.waddr + 8'h01;
            end
          endcase
          next_r.wphase = (r.wphase == 2'h2) ? 2'h0 : r.wphase + 2'h1;
        end
        SEL_MASK: begin
          if (r.key_cnt == KEY_READS) begin
            next_r.cmd = HOST_DATA_IN; // RQ18
          end else begin
            next_r.mask = HOST_DATA_IN;
          end
        end
        SEL_CMD: next_r.cmd = HOST_DATA_IN;
        default: next_r = next_r;
      endcase
    end

    // Pin registers
    next_r.pin = '{pix: PIXEL_IN, blank_n: BLANK_N, sync_n: SYNC_N}; // RQ1

    // Look-up pixel; the held index repeats during a host table access
    idx = r.pin.pix & r.mask; // RQ2
    if (!r.rd_s[2] || !r.wr_s[2]) begin
      idx = r.last_idx; // RQ20
    end
    next_r.last_idx = idx;
    entry = lut[idx];
    lut_px.rgb.red = dcpp_widen(entry[17:12]); // RQ3
    lut_px.rgb.green = dcpp_widen(entry[11:6]);
    lut_px.rgb.blue = dcpp_widen(entry[5:0]);
    lut_px.blank_n = r.pin.blank_n; // RQ7
    lut_px.sync_on = r.pin.sync_n; // RQ9

    // Direct pixel assembly from the latest byte and held bytes
    dir_px.blank_n = r.hold_blank_n;
    dir_px.sync_on = r.hold_sync_n;
    dir_px.rgb = '0;
    case (mode) // RQ5
      DCPP_D15: dir_px.rgb = '{red: {r.pin.pix[6:2], 3'h0},
                               green: {r.pin.pix[1:0], r.byte0[7:5], 3'h0},
                               blue: {r.byte0[4:0], 3'h0}};
      DCPP_D16: dir_px.rgb = '{red: {r.pin.pix[7:3], 3'h0},
                               green: {r.pin.pix[2:0], r.byte0[7:5], 2'h0},
                               blue: {r.byte0[4:0], 3'h0}};
      DCPP_D24: dir_px.rgb = '{red: r.pin.pix, green: r.byte1, blue: r.byte0};
      default: dir_px.rgb = '0;
    endcase

    // Byte phase; held at zero while blank is seen low on byte zero
    if (mode == DCPP_LUT || !r.pin.blank_n && r.phase == 2'h0) begin
      next_r.phase = 2'h0; // RQ25
    end else if (r.phase == last_ph) begin
      next_r.phase = 2'h0; // RQ4
    end else begin
      next_r.phase = r.phase + 2'h1; // RQ26
    end
    // Byte zero / blue edge: capture byte and sample blank and sync
    if (r.phase == 2'h0) begin
      next_r.byte0 = r.pin.pix; // RQ8
      next_r.hold_blank_n = r.pin.blank_n; // RQ8
      next_r.hold_sync_n = r.pin.sync_n; // RQ9
    end
    if (r.phase == 2'h1) begin
      next_r.byte1 = r.pin.pix;
    end

    // Pipeline: look-up three clocks, 15/16-bit four, 24-bit six
    if (mode == DCPP_LUT) begin
      next_r.st1 = lut_px; // RQ22
      next_r.out = r.st1;
    end else begin
      // Load stage one with the direct pixel on the last byte of each pixel
      if (r.phase == last_ph && r.hold_blank_n) begin
        next_r.st1 = dir_px; // RQ4
      end else if (r.phase == 2'h0 && !r.pin.blank_n) begin
        // Blanked pixel still carries sync so retrace pulses reach the outputs
        next_r.st1 = '{rgb: '0, blank_n: 1'b0, sync_on: r.pin.sync_n}; // RQ7
      end
      next_r.st2 = r.st1;
      next_r.st3 = r.st2;
      next_r.st4 = r.st3;
      next_r.out = (mode == DCPP_D24) ? r.st4 : r.st2; // RQ22
    end

    // Sense: held high in sleep
    next_r.sense_n = SLEEP ? 1'b1 : !(|OVER_THRESH); // RQ14

    if (!RST_N) begin
      next_r = '0;
      next_r.rd_s = 3'h7;
      next_r.wr_s = 3'h7;
      next_r.cmd = CMD_RESET; // RQ21
      next_r.mask = MASK_RESET;
      next_r.sense_n = 1'b1;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // State register
  always_ff @(posedge REF_CLK) begin
    r <= next_r;
  end

  // Table storage written by the host port
  always_ff @(posedge REF_CLK) begin
    if (lut_we) begin
      lut[lut_wa] <= lut_wd;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Blank low forces converter input to zero
  assign DAC_RED = r.out.blank_n ? r.out.rgb.red : 8'h00; // RQ6
  assign DAC_GREEN = r.out.blank_n ? r.out.rgb.green : 8'h00; // RQ6
  assign DAC_BLUE = r.out.blank_n ? r.out.rgb.blue : 8'h00; // RQ6
  assign DAC_BLANK_N = r.out.blank_n; // RQ6
  assign SYNC_PEDESTAL = {3{r.out.sync_on}} & r.cmd[CMD_PULSE_HI:CMD_PULSE_LO]; // RQ10 RQ11
  assign SETUP_PEDESTAL = SETUP; // RQ13
  assign SENSE_N = r.sense_n;
  assign HOST_DATA_OUT = r.rdata;
  assign HOST_DATA_OE = r.oe; // RQ15

endmodule
`default_nettype wire

/* File: tb/dcpp_core_properties.sv */
// Concurrent checks on the palette pixel, sense and host port behaviour
`timescale 1ns/1ps
`default_nettype none
module dcpp_core_properties (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic BLANK_N,
  input wire logic SYNC_N,
  input wire logic SETUP,
  input wire logic SLEEP,
  input wire logic [2:0] OVER_THRESH,
  input wire logic RD_N,
  input wire logic HOST_DATA_OE,
  input wire logic [7:0] DAC_RED,
  input wire logic [7:0] DAC_GREEN,
  input wire logic [7:0] DAC_BLUE,
  input wire logic DAC_BLANK_N,
  input wire logic [2:0] SYNC_PEDESTAL,
  input wire logic SETUP_PEDESTAL,
  input wire logic SENSE_N
);
  // ==========================================================================
  // Saturating idle counters
  // ==========================================================================
  logic [3:0] rd_idle; // Cycles with the read strobe high
  logic [3:0] blank_low; // Cycles with blank low
  logic [3:0] sync_low; // Cycles with sync low

  // Count up while the level holds, clear otherwise
  function automatic logic [3:0] bump(input logic [3:0] c, input logic hold);
    return !hold ? 4'h0 : (c == 4'hF) ? c : c + 4'h1;
  endfunction

  // Counters clear in reset so old levels never leak across it
  always_ff @(posedge REF_CLK) begin
    rd_idle <= RST_N ? bump(rd_idle, RD_N) : 4'h0;
    blank_low <= RST_N ? bump(blank_low, !BLANK_N) : 4'h0;
    sync_low <= RST_N ? bump(sync_low, !SYNC_N) : 4'h0;
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sense_low_a: assert property ((!SLEEP && |OVER_THRESH) |=> !SENSE_N)
    else $error("sense not low above threshold");
  sense_sleep_a: assert property (SLEEP |=> SENSE_N)
    else $error("sense not high in sleep");
  sense_clear_a: assert property ((!SLEEP && OVER_THRESH == 3'h0) |=> SENSE_N)
    else $error("sense low without cause");
  setup_follow_a: assert property (SETUP_PEDESTAL == SETUP)
    else $error("setup pedestal differs from select");
  blank_dark_a: assert property (!DAC_BLANK_N |-> {DAC_RED, DAC_GREEN, DAC_BLUE} == 24'h0)
    else $error("converter data while blanked");
  blank_follow_a: assert property (blank_low >= 4'hC |-> !DAC_BLANK_N)
    else $error("blank never reached output");
  sync_off_a: assert property (sync_low >= 4'hC |-> SYNC_PEDESTAL == 3'h0)
    else $error("sync pedestal on during sync low");
  sync_cause_a: assert property (|SYNC_PEDESTAL |-> $past(SYNC_N, 3) || $past(SYNC_N, 4)
    || $past(SYNC_N, 5) || $past(SYNC_N, 6) || $past(SYNC_N, 7) || $past(SYNC_N, 8))
    else $error("sync pedestal without sync high");
  read_drive_a: assert property ($fell(RD_N) |-> ##[2:5] HOST_DATA_OE)
    else $error("read data not driven");
  read_release_a: assert property ($rose(RD_N) |-> ##[2:6] !HOST_DATA_OE)
    else $error("data bus not released");
  idle_quiet_a: assert property (rd_idle >= 4'h8 |-> !HOST_DATA_OE)
    else $error("data bus driven without read");
endmodule

bind dcpp_core dcpp_core_properties u_props (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .BLANK_N(BLANK_N), .SYNC_N(SYNC_N),
  .SETUP(SETUP), .SLEEP(SLEEP), .OVER_THRESH(OVER_THRESH), .RD_N(RD_N),
  .HOST_DATA_OE(HOST_DATA_OE), .DAC_RED(DAC_RED), .DAC_GREEN(DAC_GREEN),
  .DAC_BLUE(DAC_BLUE), .DAC_BLANK_N(DAC_BLANK_N), .SYNC_PEDESTAL(SYNC_PEDESTAL),
  .SETUP_PEDESTAL(SETUP_PEDESTAL), .SENSE_N(SENSE_N)
);
`default_nettype wire

/* File: tb/dcpp_host_model.sv */
// Host processor model driving the strobed register port
`timescale 1ns/1ps
`default_nettype none
module dcpp_host_model (
  input wire logic clk,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] sel,
  output logic [7:0] dout,
  input wire logic [7:0] din
);
  // ==========================================================================
  // Idle levels and bus cycles
  // ==========================================================================
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    sel = 3'h0;
    dout = 8'h00;
  end

  // Select stable over the strobe, data held well past its rise
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    sel <= s;
    dout <= d;
    repeat (2) @(posedge clk);
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (5) @(posedge clk);
    dout <= ~d; // Hold over, stale value must not linger
  endtask

  // Long low strobe covers the synchronizer delay before sampling
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(posedge clk);
    sel <= s;
    @(posedge clk);
    rd_n <= 1'b0;
    repeat (7) @(posedge clk);
    d = din;
    rd_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_direct_color_palette_ports.sv */
// Self-checking bench for the direct color palette ports
`timescale 1ns/1ps
`default_nettype none
module test_direct_color_palette_ports;
  import dcpp_pkg::*;
  localparam logic [7:0] ID = 8'h3C; // Identification value, arbitrary
  logic clk, rst_n, blank_n, sync_n, setup, sleep, rd_n, wr_n, oe, dbn, sense_n, sp, bl;
  logic [7:0] pix, h_dout, bus, dout, d, r, g, b, p, b0, b1, b2;
  logic [2:0] over, sel, ped, m, pb;
  logic [8:0] e;
  logic [8:0] q [$]; // Pixels in flight with their blank
  logic [17:0] lut [0:15]; // Table model
  dcpp_rgb_t dac;
  int err_count, samples_checked, seed;

  // Data bus level from every driver
  assign bus = oe ? dout : h_dout;

  dcpp_core #(.ID_VALUE(ID)) DUT (
    .REF_CLK(clk), .RST_N(rst_n), .PIXEL_IN(pix), .BLANK_N(blank_n), .SYNC_N(sync_n),
    .SETUP(setup), .SLEEP(sleep), .OVER_THRESH(over), .RD_N(rd_n), .WR_N(wr_n),
    .REG_SELECT(sel), .HOST_DATA_IN(bus), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
    .DAC_RED(dac.red), .DAC_GREEN(dac.green), .DAC_BLUE(dac.blue), .DAC_BLANK_N(dbn),
    .SYNC_PEDESTAL(ped), .SETUP_PEDESTAL(sp), .SENSE_N(sense_n)
  );
  dcpp_host_model h (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .dout(h_dout), .din(bus));

  // ==========================================================================
  // Clock, checking and closing
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Controller drives one bus cycle
  task automatic vid(input logic [7:0] x, input logic bn, input logic sn);
    @(posedge clk);
    pix <= x;
    blank_n <= bn;
    sync_n <= sn;
  endtask

  // Table word on the top six converter bits
  function automatic dcpp_rgb_t lutc(input logic [17:0] w);
    return {w[17:12], 2'h0, w[11:6], 2'h0, w[5:0], 2'h0};
  endfunction

  // Direct color byte mapping
  function automatic dcpp_rgb_t dmap(input logic [2:0] md, input logic [7:0] x0, x1, x2);
    dcpp_rgb_t c;
    c = {x2, x1, x0};
    if (md == MODE_D15) begin
      c = {x1[6:2], 3'h0, x1[1:0], x0[7:5], 3'h0, x0[4:0], 3'h0};
    end else if (md == MODE_D16) begin
      c = {x1[7:3], 3'h0, x1[2:0], x0[7:5], 2'h0, x0[4:0], 3'h0};
    end
    return c;
  endfunction

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 25;
    rst_n = 1'b0;
    pix = 8'h00;
    blank_n = 1'b0;
    sync_n = 1'b1;
    setup = 1'b0;
    sleep = 1'b0;
    over = 3'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("dac", dac, 24'h0);
    check("oe", oe, 1'b0);
    check("sense", sense_n, 1'b1);
    h.rd(SEL_CMD, d);
    check("cmd", d, CMD_RESET);
    h.rd(SEL_MASK, d);
    check("mask", d, MASK_RESET);
    h.rd(3'h4, d);
    check("reserved", d, 8'h00);
    // Sense and setup with random comparator results
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      over <= 3'($random(seed));
      sleep <= (k % 3 == 0);
      setup <= k[0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("sense", sense_n, sleep || over == 3'h0);
      check("setup", sp, setup);
    end
    // Fill sixteen entries through the auto-incrementing address
    h.wr(SEL_MASK, 8'h0F);
    h.wr(SEL_WR_ADDR, 8'h00);
    for (int i = 0; i < 16; i++) begin
      r = 8'($random(seed));
      g = 8'($random(seed));
      b = 8'($random(seed));
      lut[i] = {r[5:0], g[5:0], b[5:0]};
      h.wr(SEL_COLOR, r);
      h.wr(SEL_COLOR, g);
      h.wr(SEL_COLOR, b);
    end
    h.wr(SEL_RD_ADDR, 8'h0E);
    for (int i = 14; i < 16; i++) begin
      for (int j = 2; j >= 0; j--) begin
        h.rd(SEL_COLOR, d);
        check("color", d[5:0], lut[i][j*6 +: 6]);
      end
    end
    // Look-up video with random pixels, mask and blank gaps
    for (int k = 0; k < 48; k++) begin
      p = 8'($random(seed));
      bl = (k % 7 != 6);
      vid(p, bl, 1'b1);
      q.push_back({bl, p});
      @(negedge clk);
      if (k >= 3) begin
        e = q.pop_front();
        check("lut", dac, e[8] ? lutc(lut[e[3:0]]) : 24'h0);
        check("blank", dbn, e[8]);
      end
    end
    // Each direct mode with random bytes and pulse enables
    for (int i = 0; i < 3; i++) begin
      m = MODE_D15 + 3'(i);
      pb = 3'($random(seed));
      h.wr(SEL_CMD, {m, pb, 2'h0});
      h.rd(SEL_CMD, d);
      check("cmd", d, {m, pb, 2'h0});
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      repeat (3) vid(8'h00, 1'b0, 1'b1);
      repeat (13) vid(8'h00, 1'b0, 1'b0);
      @(negedge clk);
      check("syncoff", ped, 3'h0);
      repeat (3) vid(8'h00, 1'b0, 1'b1);
      repeat (8) begin
        vid(b0, 1'b1, 1'b1);
        vid(b1, 1'b1, 1'b1);
        if (m == MODE_D24) vid(b2, 1'b1, 1'b1);
      end
      @(negedge clk);
      check("direct", dac, dmap(m, b0, b1, b2));
      check("pedestal", ped, pb);
      check("dblank", dbn, 1'b1);
      repeat (14) vid(8'h00, 1'b0, 1'b1);
      @(negedge clk);
      check("dark", dac, 24'h0);
    end
    // Key sequence of mask reads
    h.wr(SEL_CMD, CMD_RESET);
    for (int k = 0; k < 5; k++) begin
      h.rd(SEL_MASK, d);
      check("key", d, k < 3 ? 8'h0F : k == 3 ? ID : CMD_RESET);
    end
    h.wr(SEL_MASK, 8'hA4);
    h.rd(SEL_CMD, d);
    check("keyed", d, 8'hA4);
    end_sim();
  end
endmodule
`default_nettype wire
